/* pkg/pcg_map.svh */
// Register offsets, field positions and reset values of the peripheral clock gate block
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH
// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define PCG_GATE0_OFS 12'h024
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PCG_TIMER_TWO 17
`define PCG_TIMER_ONE 16
`define PCG_TIMER_ZERO 15
`define PCG_TWOWIRE_ZERO 13
`define PCG_SERIAL_ONE 10
`define PCG_SERIAL_ZERO 9
`define PCG_SYNC_SERIAL_ONE 6
`define PCG_DMA 5
`define PCG_USB 3
`define PCG_PIN_ONE 1
`define PCG_PIN_ZERO 0
// ----------------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------------
`define PCG_RW_MASK 18'h3a66b
`define PCG_RO_MASK 18'h05994
`define PCG_RESET 18'h3ffff
`define PCG_NUM_GATES 11
`endif

/* pkg/pcg_pkg.sv */
// Types of the peripheral clock gate block
`default_nettype none
package pcg_pkg;
    typedef enum logic [2:0] {
        PCG_WR_IDLE = 3'h1,
        PCG_WR_RESP = 3'h2,
        PCG_WR_SPARE = 3'h4
    } pcg_wr_e;
    typedef struct packed {
        logic [17:0] gate;
    } pcg_gates_s;
    typedef struct packed {
        logic [10:0] clk_en;
        logic [10:0] access_block;
    } pcg_out_s;
endpackage
`default_nettype wire

/* hdl/pcg_top.sv */
// Peripheral clock gate register, low half, with AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "pcg_map.svh"
module pcg_top (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output pcg_pkg::pcg_out_s periph
);
    // ------------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------------
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [11:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    pcg_pkg::pcg_gates_s gates_r, gates_nxt;
    logic [31:0] wmask;
    logic do_write;

    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready = !w_got_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    always_comb begin
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        gates_nxt = gates_r;
        wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
        do_write = aw_got_r && w_got_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (do_write) begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            if ({awaddr_r[11:2], 2'b00} == `PCG_GATE0_OFS) begin
                bresp_nxt = 2'b00;
                gates_nxt.gate = (gates_r.gate & ~(`PCG_RW_MASK & wmask[17:0]))
                    | (wdata_r[17:0] & `PCG_RW_MASK & wmask[17:0]) | `PCG_RO_MASK;
            end else begin
                bresp_nxt = 2'b10;
            end
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'b00;
            gates_r <= `PCG_RESET;
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            gates_r <= gates_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            if ({s_axi_araddr[11:2], 2'b00} == `PCG_GATE0_OFS) begin
                rdata_nxt = {14'h0000, gates_r.gate};
                rresp_nxt = 2'b00;
            end else begin
                rdata_nxt = 32'h0000_0000;
                rresp_nxt = 2'b10;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'b00;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Gate outputs
    // ------------------------------------------------------------------------
    localparam int unsigned POS [11] = '{`PCG_PIN_ZERO, `PCG_PIN_ONE, `PCG_USB, `PCG_DMA,
        `PCG_SYNC_SERIAL_ONE, `PCG_SERIAL_ZERO, `PCG_SERIAL_ONE, `PCG_TWOWIRE_ZERO,
        `PCG_TIMER_ZERO, `PCG_TIMER_ONE, `PCG_TIMER_TWO};
    genvar gi;
    generate
        for (gi = 0; gi < `PCG_NUM_GATES; gi++) begin : g_gate
            assign periph.clk_en[gi] = !gates_r.gate[POS[gi]];
            assign periph.access_block[gi] = gates_r.gate[POS[gi]];
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_reset_ones;
        @(posedge mclk) $rose(nrst) |-> gates_r.gate == `PCG_RESET;
    endproperty
    a_reset_ones: assert property (p_reset_ones) else $error("gates not one after reset");

    property p_clk_follows;
        @(posedge mclk) disable iff (!nrst) periph.clk_en[10] == !gates_r.gate[17]
            && periph.clk_en[0] == !gates_r.gate[0];
    endproperty
    a_clk_follows: assert property (p_clk_follows) else $error("clock enable wrong");

    property p_block;
        @(posedge mclk) disable iff (!nrst) periph.access_block == ~periph.clk_en;
    endproperty
    a_block: assert property (p_block) else $error("access block mismatch");

    property p_reserved;
        @(posedge mclk) disable iff (!nrst) (gates_r.gate & `PCG_RO_MASK) == `PCG_RO_MASK;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit not one");

    property p_write_timer;
        @(posedge mclk) disable iff (!nrst)
            do_write && awaddr_r == `PCG_GATE0_OFS && wstrb_r[2]
            |=> gates_r.gate[17:16] == $past(wdata_r[17:16]);
    endproperty
    a_write_timer: assert property (p_write_timer) else $error("timer gate write lost");

    property p_write_mid;
        @(posedge mclk) disable iff (!nrst)
            do_write && awaddr_r == `PCG_GATE0_OFS && wstrb_r[1]
            |=> gates_r.gate[13] == $past(wdata_r[13]) && gates_r.gate[10:9] == $past(wdata_r[10:9]);
    endproperty
    a_write_mid: assert property (p_write_mid) else $error("serial gate write lost");

    property p_write_low;
        @(posedge mclk) disable iff (!nrst)
            do_write && awaddr_r == `PCG_GATE0_OFS && wstrb_r[0]
            |=> gates_r.gate[6:5] == $past(wdata_r[6:5]) && gates_r.gate[3] == $past(wdata_r[3]);
    endproperty
    a_write_low: assert property (p_write_low) else $error("low gate write lost");

    property p_write_pin;
        @(posedge mclk) disable iff (!nrst)
            do_write && awaddr_r == `PCG_GATE0_OFS && wstrb_r[0]
            |=> gates_r.gate[1:0] == $past(wdata_r[1:0]);
    endproperty
    a_write_pin: assert property (p_write_pin) else $error("pin gate write lost");

    property p_hold;
        @(posedge mclk) disable iff (!nrst) !do_write |=> $stable(gates_r.gate);
    endproperty
    a_hold: assert property (p_hold) else $error("gate changed without write");

    c_write: cover property (@(posedge mclk) disable iff (!nrst) do_write && bresp_nxt == 2'b00);
    c_read: cover property (@(posedge mclk) disable iff (!nrst) rvalid_r && rresp_r == 2'b00);
    c_ungate: cover property (@(posedge mclk) disable iff (!nrst) $rose(periph.clk_en[10]));
endmodule
`default_nettype wire

/* tb/pcg_top_tb_top.sv */
// Self-checking testbench of the peripheral clock gate block
`timescale 1ns/100ps
`default_nettype none
module pcg_top_tb_top;
    logic mclk;
    logic nrst;
    logic [11:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [11:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    pcg_pkg::pcg_out_s periph;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [4:0] pos [11] = '{5'h00, 5'h01, 5'h03, 5'h05, 5'h06, 5'h09, 5'h0a, 5'h0d, 5'h0f, 5'h10, 5'h11};

    pcg_top uut (.mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .periph(periph));

    // ------------------------------------------------------------------------
    // Clock, timeout and verdict
    // ------------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic final_report();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            final_report();
        end
    end

    // ------------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        bit aw_ok;
        bit w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge mclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge mclk);
            if (awvalid && awready) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge mclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        check(periph.clk_en, 32'h0);
        check(periph.access_block, 32'h7ff);
        rd(12'h024, d, r);
        check(d, 32'h0003ffff);
    endtask

    task automatic t_each();
        logic [31:0] v;
        logic [31:0] d;
        logic [1:0] r;
        logic [10:0] e;
        logic [10:0] nb;
        for (int i = 0; i < 11; i++) begin
            v = 32'h0003ffff & ~(32'h1 << pos[i]);
            e = 11'h1 << i;
            nb = ~e;
            wr(12'h024, v, 4'hf, r);
            rd(12'h024, d, r);
            check(d, v);
            check(periph.clk_en, e);
            check(periph.access_block, nb);
        end
    endtask

    task automatic t_strobe();
        logic [31:0] d;
        logic [1:0] r;
        wr(12'h024, 32'h0, 4'hf, r);
        rd(12'h024, d, r);
        check(d, 32'h00005994);
        check(periph.clk_en, 32'h7ff);
        wr(12'h024, 32'h0003ffff, 4'h4, r);
        check(r, 32'h0);
        rd(12'h024, d, r);
        check(d, 32'h00035994);
        check(periph.clk_en, 32'h1ff);
    endtask

    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        wr(12'h028, 32'h0, 4'hf, r);
        check(r, 32'h2);
        rd(12'h028, d, r);
        check(r, 32'h2);
        check(d, 32'h0);
        rd(12'h024, d, r);
        check(r, 32'h0);
        check(d, 32'h00035994);
        check(periph.access_block, 32'h600);
    endtask

    task automatic t_lanes();
        logic [31:0] d;
        logic [1:0] r;
        wr(12'h024, 32'h0003ffff, 4'h2, r);
        check(r, 32'h0);
        rd(12'h024, d, r);
        check(d, 32'h0003ff94);
        check(periph.clk_en, 32'h1f);
        wr(12'h024, 32'h0003ffff, 4'h1, r);
        rd(12'h024, d, r);
        check(d, 32'h0003ffff);
        check(periph.clk_en, 32'h0);
        wr(12'h024, 32'h0, 4'h1, r);
        check(periph.clk_en, 32'h1f);
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        check(periph.access_block, 32'h7ff);
        nrst <= 1'b1;
        rd(12'h024, d, r);
        check(d, 32'h0003ffff);
        check(periph.clk_en, 32'h0);
    endtask

    initial begin
        nrst = 1'b0;
        awaddr = 12'h000;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 12'h000;
        arvalid = 1'b0;
        rready = 1'b0;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_each();
        t_strobe();
        t_unmapped();
        t_lanes();
        final_report();
    end
endmodule
`default_nettype wire
